// ### shared/ssil_pkg.sv
`default_nettype none
package ssil_pkg;
	// Register offsets on the plain register port
	localparam logic [2:0] SSIL_ADDR_MODE = 3'h0;
	localparam logic [2:0] SSIL_ADDR_CTRL = 3'h1;
	localparam logic [2:0] SSIL_ADDR_STAT = 3'h2;
	localparam logic [2:0] SSIL_ADDR_TXD = 3'h3;
	localparam logic [2:0] SSIL_ADDR_RXD = 3'h4;
	localparam logic [2:0] SSIL_ADDR_PORT = 3'h5;
	localparam logic [2:0] SSIL_ADDR_DIV = 3'h6;
	// serial_control_reg fields
	localparam int SSIL_CTRL_TIE = 7;
	localparam int SSIL_CTRL_RIE = 6;
	localparam int SSIL_CTRL_TE = 5;
	localparam int SSIL_CTRL_RE = 4;
	localparam int SSIL_CTRL_TX_END_IRQ_ENABLE = 2;
	localparam int SSIL_CTRL_CKS_HI = 1;
	localparam int SSIL_CTRL_CKS_LO = 0;
	// serial_mode_reg fields
	localparam int SSIL_MODE_SYNC = 7;
	localparam int SSIL_MODE_PAR_EN = 5;
	localparam int SSIL_MODE_PAR_ODD = 4;
	// serial_status_reg fields
	localparam int SSIL_STAT_TXE = 7;
	localparam int SSIL_STAT_RXF = 6;
	localparam int SSIL_STAT_OVR = 5;
	localparam int SSIL_STAT_FER = 4;
	localparam int SSIL_STAT_PER = 3;
	localparam int SSIL_STAT_TX_END_FLAG = 2;
	// Port register fields
	localparam int SSIL_PORT_TXD_DATA = 0;
	localparam int SSIL_PORT_TXD_DIR = 1;
	localparam int SSIL_PORT_SCK_DATA = 2;
	localparam int SSIL_PORT_SCK_DIR = 3;
	localparam int SSIL_PORT_TXD_PIN = 4;
	localparam int SSIL_PORT_SCK_PIN = 5;
	localparam int SSIL_PORT_RXD_PIN = 6;
	// Values after reset
	localparam logic [7:0] SSIL_CTRL_RST = 8'h00;
	localparam logic [7:0] SSIL_MODE_RST = 8'h00;
	localparam logic [3:0] SSIL_PORT_RST = 4'h0;
	localparam logic [7:0] SSIL_DIV_RST = 8'h0b;
	localparam logic [10:0] SSIL_SHIFT_IDLE = 11'h7ff;
	// Base clock runs at sixteen times the bit rate
	localparam logic [3:0] SSIL_BASE_LAST = 4'hf;
	localparam logic [3:0] SSIL_SAMPLE_TICK = 4'h7;
	localparam logic [3:0] SSIL_SCK_RISE_TICK = 4'h7;
	localparam logic [3:0] SSIL_SYNC_BITS = 4'h8;
	localparam logic [3:0] SSIL_ASYNC_BITS = 4'ha;
	localparam logic [3:0] SSIL_ASYNC_BITS_PAR = 4'hb;
endpackage
`default_nettype wire

// ### core/ssil_serial_comm_unit.sv
// Functional notes
// (RULE_01) Four sources share one interrupt output
// (RULE_02) Transmit-empty request when flag and enable
// (RULE_03) Transmit-end request when flag and enable
// (RULE_04) Receive-full request when flag and enable
// (RULE_05) Error request on any error flag
// (RULE_06) Transmit and receive enables gate requests
// (RULE_07) Transmit-empty flag resets to one
// (RULE_08) Transmit-end flag resets to one
// (RULE_09) Holding write clears, transfer sets empty
// (RULE_10) Software checks empty before each write
// (RULE_11) Overrun keeps data, sets overrun flag
// (RULE_12) Framing or parity error still stores data
// (RULE_13) Full flag at frame end means overrun
// (RULE_14) Reading receive holding clears full flag
// (RULE_15) Break keeps receiving, framing sets again
// (RULE_16) Transmit disable resets transmitter, port owns pin
// (RULE_17) Sync transmit blocked by errors
// (RULE_18) Async receive samples eighth of sixteen
// (RULE_19) Software reads receive holding once, early
// (RULE_20) Clock pin low briefly after switch
// (RULE_21) Software switches clock pin glitch-free
// (RULE_22) Data pin high one cycle after switch
// (RULE_23) Requests are flag AND enable levels
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ssil_serial_comm_unit
	import ssil_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic rx_data_pin_in,
	input wire logic tx_data_pin_in,
	output logic tx_data_pin_out,
	output logic tx_data_pin_oe,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	output logic receive_full_irq,
	output logic tx_empty_irq,
	output logic tx_end_irq,
	output logic rx_error_irq,
	output logic serial_irq
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [3:0] port;
		logic [7:0] div;
		logic [7:0] div_cnt;
		logic sck_m;
		logic sck_s;
		logic sck_d;
		logic rxd_m;
		logic rxd_s;
		logic txp_m;
		logic txp_s;
		logic tx_empty;
		logic tx_end;
		logic rx_full;
		logic ovr;
		logic framing_flag;
		logic per;
		logic [7:0] tx_holding_reg;
		logic [7:0] rx_holding_reg;
		logic [7:0] rdata;
		logic tx_busy;
		logic [3:0] tx_tick;
		logic [3:0] tx_cnt;
		logic [10:0] tx_shift_reg;
		logic rx_busy;
		logic [3:0] rx_tick;
		logic [3:0] rx_cnt;
		logic [10:0] rx_shift_reg;
		logic sy_busy;
		logic [3:0] sy_tick;
		logic sy_tx;
		logic sck_was_clk;
		logic txd_was_sync;
	} ssil_state_t;

	ssil_state_t s;
	ssil_state_t next_s;

	logic sync;
	logic te;
	logic re;
	logic ext;
	logic par_en;
	logic err;
	logic tick;
	logic srise;
	logic sfall;
	logic clk_mode;
	logic in_mode;
	logic sck_lvl;
	logic sck_glitch;
	logic txd_glitch;
	logic txd_line;
	logic done;
	logic [7:0] rdat;
	logic rfe;
	logic rpe;
	logic [3:0] alen;

	assign sync = s.mode[SSIL_MODE_SYNC];
	assign par_en = s.mode[SSIL_MODE_PAR_EN];
	assign te = s.ctrl[SSIL_CTRL_TE];
	assign re = s.ctrl[SSIL_CTRL_RE];
	assign ext = s.ctrl[SSIL_CTRL_CKS_HI];
	assign err = s.ovr | s.framing_flag | s.per;
	// At or past the divisor, so lowering it never stalls the base clock
	assign tick = (s.div_cnt >= s.div);
	assign alen = par_en ? SSIL_ASYNC_BITS_PAR : SSIL_ASYNC_BITS;
	// Clock pin roles: own clock out, clock in, or general port
	assign clk_mode = sync & ~ext;
	assign in_mode = sync & ext;
	assign sck_lvl = ~s.sy_busy | s.sy_tick[3];
	// Internal clock edges line up with the level change on the pin
	assign srise = ext ? (s.sck_s & ~s.sck_d) : (tick & (s.sy_tick == SSIL_SCK_RISE_TICK));
	assign sfall = ext ? (~s.sck_s & s.sck_d) : (tick & (s.sy_tick == SSIL_BASE_LAST));
	// Held sync clock dropping straight to a port shows a short low
	assign sck_glitch = s.sck_was_clk & ~clk_mode & ~in_mode; // RULE_20
	assign txd_glitch = s.txd_was_sync & ~te; // RULE_22
	assign txd_line = (sync | s.tx_busy) ? s.tx_shift_reg[0] : 1'b1;

	always_comb begin
		next_s = s;
		done = 1'b0;
		rdat = 8'h00;
		rfe = 1'b0;
		rpe = 1'b0;
		next_s.div_cnt = tick ? 8'h00 : s.div_cnt + 8'h01;
		next_s.sck_m = serial_clock_pin_in;
		next_s.sck_s = s.sck_m;
		next_s.sck_d = s.sck_s;
		next_s.rxd_m = rx_data_pin_in;
		next_s.rxd_s = s.rxd_m;
		next_s.txp_m = tx_data_pin_in;
		next_s.txp_s = s.txp_m;
		next_s.sck_was_clk = clk_mode;
		next_s.txd_was_sync = te & sync;
		next_s.rdata = 8'h00;

		// Transmitter, asynchronous frames
		if (!te) begin
			next_s.tx_busy = 1'b0; // RULE_16
			next_s.tx_shift_reg = SSIL_SHIFT_IDLE; // RULE_16
		end else if (!sync) begin
			if (!s.tx_busy) begin
				if (!s.tx_empty) begin
					if (par_en) begin
						next_s.tx_shift_reg = {1'b1, (^s.tx_holding_reg) ^ s.mode[SSIL_MODE_PAR_ODD], s.tx_holding_reg, 1'b0};
					end else begin
						next_s.tx_shift_reg = {2'b11, s.tx_holding_reg, 1'b0};
					end
					next_s.tx_cnt = alen;
					next_s.tx_busy = 1'b1;
					next_s.tx_tick = 4'h0;
					next_s.tx_empty = 1'b1; // RULE_09
					next_s.tx_end = 1'b0;
				end
			end else if (tick) begin
				next_s.tx_tick = s.tx_tick + 4'h1;
				if (s.tx_tick == SSIL_BASE_LAST) begin
					next_s.tx_shift_reg = {1'b1, s.tx_shift_reg[10:1]};
					next_s.tx_cnt = s.tx_cnt - 4'h1;
					if (s.tx_cnt == 4'h1) begin
						next_s.tx_busy = 1'b0;
						if (s.tx_empty) begin
							next_s.tx_end = 1'b1;
						end
					end
				end
			end
		end

		// Clocked synchronous engine, transmit and receive share it
		if (!sync || (!te && !re)) begin
			next_s.sy_busy = 1'b0;
		end else if (!s.sy_busy) begin
			if (!err && ((te && !s.tx_empty) || (re && !te))) begin // RULE_17
				next_s.sy_busy = 1'b1;
				next_s.sy_tick = 4'h0;
				next_s.tx_cnt = SSIL_SYNC_BITS;
				next_s.sy_tx = te;
				if (te) begin
					next_s.tx_shift_reg = {3'b111, s.tx_holding_reg};
					next_s.tx_empty = 1'b1; // RULE_09
					next_s.tx_end = 1'b0;
				end
			end
		end else begin
			if (tick && !ext) begin
				next_s.sy_tick = s.sy_tick + 4'h1;
			end
			// No shift on a fall before the first rise, so the LSB stays on the line
			if (sfall && s.tx_cnt != SSIL_SYNC_BITS) begin
				next_s.tx_shift_reg = {1'b1, s.tx_shift_reg[10:1]};
			end
			if (srise) begin
				next_s.rx_shift_reg = {s.rxd_s, s.rx_shift_reg[10:1]};
				next_s.tx_cnt = s.tx_cnt - 4'h1;
				if (s.tx_cnt == 4'h1) begin
					next_s.sy_busy = 1'b0;
					if (s.sy_tx && te && s.tx_empty) begin
						next_s.tx_end = 1'b1;
					end
					if (re) begin
						done = 1'b1;
						rdat = next_s.rx_shift_reg[10:3];
					end
				end
			end
		end

		// Receiver, asynchronous frames on the base clock
		if (!re || sync) begin
			next_s.rx_busy = 1'b0;
		end else if (!s.rx_busy) begin
			// Low line in idle starts a frame; a break restarts at once
			if (!s.rxd_s) begin // RULE_15
				next_s.rx_busy = 1'b1;
				next_s.rx_tick = 4'h0;
				next_s.rx_cnt = 4'h0;
			end
		end else if (tick) begin
			next_s.rx_tick = s.rx_tick + 4'h1;
			if (s.rx_tick == SSIL_SAMPLE_TICK) begin // RULE_18
				next_s.rx_shift_reg = {s.rxd_s, s.rx_shift_reg[10:1]};
				next_s.rx_cnt = s.rx_cnt + 4'h1;
				if (s.rx_cnt == 4'h0 && s.rxd_s) begin
					next_s.rx_busy = 1'b0;
				end else if (s.rx_cnt + 4'h1 == alen) begin
					next_s.rx_busy = 1'b0;
					done = 1'b1;
					rdat = par_en ? next_s.rx_shift_reg[8:1] : next_s.rx_shift_reg[9:2];
					rfe = ~s.rxd_s;
					rpe = par_en & ((^next_s.rx_shift_reg[9:1]) != s.mode[SSIL_MODE_PAR_ODD]);
				end
			end
		end

		// Register port
		if (reg_wr) begin
			case (reg_addr)
				SSIL_ADDR_MODE: next_s.mode = reg_wdata;
				SSIL_ADDR_CTRL: next_s.ctrl = reg_wdata;
				SSIL_ADDR_PORT: next_s.port = reg_wdata[3:0];
				SSIL_ADDR_DIV: next_s.div = reg_wdata;
				SSIL_ADDR_TXD: begin
					// New data wins over a transfer in the same cycle
					next_s.tx_holding_reg = reg_wdata;
					next_s.tx_empty = 1'b0; // RULE_09
					next_s.tx_end = 1'b0;
				end
				SSIL_ADDR_STAT: begin
					next_s.rx_full = next_s.rx_full & reg_wdata[SSIL_STAT_RXF];
					next_s.ovr = s.ovr & reg_wdata[SSIL_STAT_OVR];
					next_s.framing_flag = s.framing_flag & reg_wdata[SSIL_STAT_FER];
					next_s.per = s.per & reg_wdata[SSIL_STAT_PER];
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				SSIL_ADDR_MODE: next_s.rdata = s.mode;
				SSIL_ADDR_CTRL: next_s.rdata = s.ctrl;
				SSIL_ADDR_DIV: next_s.rdata = s.div;
				SSIL_ADDR_TXD: next_s.rdata = s.tx_holding_reg;
				SSIL_ADDR_RXD: begin
					next_s.rdata = s.rx_holding_reg;
					next_s.rx_full = 1'b0; // RULE_14
				end
				SSIL_ADDR_STAT: begin
					next_s.rdata[SSIL_STAT_TXE] = s.tx_empty;
					next_s.rdata[SSIL_STAT_RXF] = s.rx_full;
					next_s.rdata[SSIL_STAT_OVR] = s.ovr;
					next_s.rdata[SSIL_STAT_FER] = s.framing_flag;
					next_s.rdata[SSIL_STAT_PER] = s.per;
					next_s.rdata[SSIL_STAT_TX_END_FLAG] = s.tx_end;
				end
				SSIL_ADDR_PORT: begin
					next_s.rdata[3:0] = s.port;
					next_s.rdata[SSIL_PORT_TXD_PIN] = s.txp_s;
					next_s.rdata[SSIL_PORT_SCK_PIN] = s.sck_s;
					next_s.rdata[SSIL_PORT_RXD_PIN] = s.rxd_s;
				end
				default: next_s.rdata = 8'h00;
			endcase
		end

		// Frame completion after software clears, so hardware sets win
		if (done) begin
			if (s.rx_full) begin // RULE_13
				next_s.ovr = 1'b1; // RULE_11
			end else begin
				next_s.rx_holding_reg = rdat; // RULE_12
				if (!rfe && !rpe) begin
					next_s.rx_full = 1'b1;
				end
			end
			if (rfe) begin
				next_s.framing_flag = 1'b1; // RULE_12
			end
			if (rpe) begin
				next_s.per = 1'b1; // RULE_12
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.ctrl <= SSIL_CTRL_RST;
			s.mode <= SSIL_MODE_RST;
			s.port <= SSIL_PORT_RST;
			s.div <= SSIL_DIV_RST;
			s.sck_m <= 1'b1;
			s.sck_s <= 1'b1;
			s.sck_d <= 1'b1;
			s.rxd_m <= 1'b1;
			s.rxd_s <= 1'b1;
			s.tx_empty <= 1'b1; // RULE_07
			s.tx_end <= 1'b1; // RULE_08
			s.tx_shift_reg <= SSIL_SHIFT_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;

	// Disabled transmitter hands the pin to the general port
	always_comb begin
		if (txd_glitch) begin
			tx_data_pin_out = 1'b1; // RULE_22
			tx_data_pin_oe = 1'b1;
		end else if (te) begin
			tx_data_pin_out = txd_line;
			tx_data_pin_oe = 1'b1;
		end else begin
			tx_data_pin_out = s.port[SSIL_PORT_TXD_DATA]; // RULE_16
			tx_data_pin_oe = s.port[SSIL_PORT_TXD_DIR]; // RULE_16
		end
	end

	// Glitch lasts a whole core cycle, the finest step this clock has
	always_comb begin
		if (sck_glitch) begin
			serial_clock_pin_out = 1'b0; // RULE_20
			serial_clock_pin_oe = 1'b1;
		end else if (clk_mode) begin
			serial_clock_pin_out = sck_lvl;
			serial_clock_pin_oe = 1'b1;
		end else if (in_mode) begin
			serial_clock_pin_out = 1'b1;
			serial_clock_pin_oe = 1'b0;
		end else begin
			serial_clock_pin_out = s.port[SSIL_PORT_SCK_DATA];
			serial_clock_pin_oe = s.port[SSIL_PORT_SCK_DIR];
		end
	end

	assign tx_empty_irq = s.tx_empty & s.ctrl[SSIL_CTRL_TIE]; // RULE_02 RULE_06 RULE_23
	assign tx_end_irq = s.tx_end & s.ctrl[SSIL_CTRL_TX_END_IRQ_ENABLE]; // RULE_03 RULE_23
	assign receive_full_irq = s.rx_full & s.ctrl[SSIL_CTRL_RIE]; // RULE_04 RULE_06 RULE_23
	assign rx_error_irq = err & s.ctrl[SSIL_CTRL_RIE]; // RULE_05 RULE_06 RULE_23
	assign serial_irq = tx_empty_irq | tx_end_irq | receive_full_irq | rx_error_irq; // RULE_01
endmodule // ssil_serial_comm_unit
`default_nettype wire

// ### bench/ssil_serial_comm_unit_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ssil_serial_comm_unit_sva
	import ssil_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic tx_data_pin_out,
	input wire logic tx_data_pin_oe,
	input wire logic receive_full_irq,
	input wire logic tx_empty_irq,
	input wire logic tx_end_irq,
	input wire logic rx_error_irq,
	input wire logic serial_irq
);
	logic [7:0] mode_q, ctrl_q, port_q;
	logic fresh;
	logic wr_c;
	assign wr_c = reg_wr && reg_addr == SSIL_ADDR_CTRL;
	// Shadow copies so pin checks need no view inside
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= 8'h00;
			ctrl_q <= 8'h00;
			port_q <= 8'h00;
			fresh <= 1'b1;
		end else if (reg_wr) begin
			if (reg_addr == SSIL_ADDR_MODE)
				mode_q <= reg_wdata;
			if (wr_c)
				ctrl_q <= reg_wdata;
			if (reg_addr == SSIL_ADDR_PORT)
				port_q <= reg_wdata;
			if (reg_addr == SSIL_ADDR_TXD)
				fresh <= 1'b0;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	property p_shared;
		serial_irq == (tx_empty_irq | tx_end_irq | receive_full_irq | rx_error_irq);
	endproperty
	a_shared: assert property (p_shared) else $error("shared request wrong");
	property p_txe_rst;
		fresh && wr_c && reg_wdata[SSIL_CTRL_TIE] |=> tx_empty_irq;
	endproperty
	a_txe_rst: assert property (p_txe_rst) else $error("no empty request");
	property p_tx_end_flag_rst;
		fresh && wr_c && reg_wdata[SSIL_CTRL_TX_END_IRQ_ENABLE] |=> tx_end_irq;
	endproperty
	a_tx_end_flag_rst: assert property (p_tx_end_flag_rst) else $error("no end request");
	property p_tie_off;
		wr_c && !reg_wdata[SSIL_CTRL_TIE] |=> !tx_empty_irq;
	endproperty
	a_tie_off: assert property (p_tie_off) else $error("empty request unmasked");
	property p_rie_off;
		wr_c && !reg_wdata[SSIL_CTRL_RIE] |=> !receive_full_irq && !rx_error_irq;
	endproperty
	a_rie_off: assert property (p_rie_off) else $error("rx request unmasked");
	property p_txe_clr;
		reg_wr && reg_addr == SSIL_ADDR_TXD |=> !tx_empty_irq;
	endproperty
	a_txe_clr: assert property (p_txe_clr) else $error("empty not cleared");
	property p_rxf_clr;
		reg_rd && reg_addr == SSIL_ADDR_RXD |=> !receive_full_irq;
	endproperty
	a_rxf_clr: assert property (p_rxf_clr) else $error("full not cleared");
	property p_te_off;
		wr_c && !reg_wdata[SSIL_CTRL_TE] && !mode_q[SSIL_MODE_SYNC]
			|=> tx_data_pin_out == port_q[0] && tx_data_pin_oe == port_q[1];
	endproperty
	a_te_off: assert property (p_te_off) else $error("pin not handed to port");
	property p_glitch;
		wr_c && !reg_wdata[SSIL_CTRL_TE] && ctrl_q[SSIL_CTRL_TE] && mode_q[SSIL_MODE_SYNC]
			|=> tx_data_pin_out && tx_data_pin_oe;
	endproperty
	a_glitch: assert property (p_glitch) else $error("no high after switch");
	c_ovr: cover property ($rose(rx_error_irq) && receive_full_irq);
	c_tx_end_flag: cover property ($rose(tx_end_irq));
	c_rxf: cover property ($rose(receive_full_irq));
endmodule // ssil_serial_comm_unit_sva
bind ssil_serial_comm_unit ssil_serial_comm_unit_sva chk_i (.core_clk(core_clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.tx_data_pin_out(tx_data_pin_out), .tx_data_pin_oe(tx_data_pin_oe),
	.receive_full_irq(receive_full_irq), .tx_empty_irq(tx_empty_irq), .tx_end_irq(tx_end_irq),
	.rx_error_irq(rx_error_irq), .serial_irq(serial_irq));
`default_nettype wire

// ### bench/ssil_remote.sv
`timescale 1ns/10ps
`default_nettype none
module ssil_remote #(
	parameter int BIT_NS = 80
) (
	input wire logic send,
	input wire logic [10:0] frame,
	input wire logic tx_line,
	output logic rx_line,
	output logic [7:0] got
);
	initial rx_line = 1'b1;
	// Bit 0 first; line returns to mark when done
	always @(posedge send) begin
		for (int i = 0; i < 11; i++) begin
			rx_line = frame[i];
			#(BIT_NS);
		end
		rx_line = 1'b1;
	end
	// Mid-bit sampling of the unit's output
	always @(negedge tx_line) begin
		#(BIT_NS * 3 / 2);
		for (int i = 0; i < 8; i++) begin
			got[i] = tx_line;
			#(BIT_NS);
		end
	end
endmodule // ssil_remote
`default_nettype wire

// ### bench/test_serial_status_interrupt_logic.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_status_interrupt_logic;
	import ssil_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata, got, irqs;
	logic rxd, tx_data_pin_out, tx_data_pin_oe, sck_o, sck_oe;
	logic receive_full_irq, tx_empty_irq, tx_end_irq, rx_error_irq, serial_irq;
	logic send = 1'b0;
	logic [10:0] frame = 11'h7ff;
	wire logic tx_line, sck_line;
	int failures = 0;
	int n_tests = 0;
	// Pull-ups on both pins
	assign tx_line = tx_data_pin_oe ? tx_data_pin_out : 1'b1;
	assign sck_line = sck_oe ? sck_o : 1'b1;
	assign irqs = {3'h0, serial_irq, tx_empty_irq, tx_end_irq, receive_full_irq, rx_error_irq};
	always #2.5 core_clk = ~core_clk;
	ssil_serial_comm_unit dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_data_pin_in(rxd), .tx_data_pin_in(tx_line), .tx_data_pin_out(tx_data_pin_out),
		.tx_data_pin_oe(tx_data_pin_oe), .serial_clock_pin_in(sck_line),
		.serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe),
		.receive_full_irq(receive_full_irq), .tx_empty_irq(tx_empty_irq), .tx_end_irq(tx_end_irq),
		.rx_error_irq(rx_error_irq), .serial_irq(serial_irq));
	ssil_remote far (.send(send), .frame(frame), .tx_line(tx_line), .rx_line(rxd), .got(got));
	task automatic complete_run();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] v, input logic [7:0] e);
		n_tests++;
		if (v !== e) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, v, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & m, e);
	endtask
	// Whole frame plus margin at divider 0
	task automatic tx_frame(input logic [10:0] f);
		@(posedge core_clk);
		frame <= f;
		send <= 1'b1;
		@(posedge core_clk);
		send <= 1'b0;
		repeat (12 * 16) @(posedge core_clk);
		#1;
	endtask
	initial begin
		#100us;
		failures++;
		complete_run();
	end
	initial begin
		int k;
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		rd(SSIL_ADDR_STAT, 8'hfc, 8'h84);
		chk(irqs, 8'h00);
		wr(SSIL_ADDR_DIV, 8'h00);
		wr(SSIL_ADDR_CTRL, 8'h84);
		chk(irqs, 8'h1c);
		wr(SSIL_ADDR_CTRL, 8'ha4);
		rd(SSIL_ADDR_STAT, 8'h80, 8'h80);
		wr(SSIL_ADDR_TXD, 8'h5a);
		chk(irqs, 8'h00);
		for (k = 0; k < 400 && tx_end_irq !== 1'b1; k++)
			@(posedge core_clk);
		if (k == 400) begin
			failures++;
			complete_run();
		end
		#1;
		chk(irqs, 8'h1c);
		chk(got, 8'h5a);
		wr(SSIL_ADDR_CTRL, 8'h50);
		tx_frame({2'b11, 8'h3c, 1'b0});
		chk(irqs, 8'h12);
		rd(SSIL_ADDR_RXD, 8'hff, 8'h3c);
		chk(irqs, 8'h00);
		tx_frame({2'b11, 8'h11, 1'b0});
		tx_frame({2'b11, 8'h22, 1'b0});
		chk(irqs, 8'h13);
		rd(SSIL_ADDR_STAT, 8'h78, 8'h60);
		rd(SSIL_ADDR_RXD, 8'hff, 8'h11);
		wr(SSIL_ADDR_STAT, 8'h00);
		chk(irqs, 8'h00);
		tx_frame({2'b10, 8'h7e, 1'b0});
		chk(irqs, 8'h11);
		rd(SSIL_ADDR_STAT, 8'h78, 8'h10);
		rd(SSIL_ADDR_RXD, 8'hff, 8'h7e);
		wr(SSIL_ADDR_STAT, 8'h00);
		tx_frame(11'h400);
		rd(SSIL_ADDR_STAT, 8'h10, 8'h10);
		wr(SSIL_ADDR_STAT, 8'h00);
		wr(SSIL_ADDR_MODE, 8'h20);
		tx_frame({2'b10, 8'h01, 1'b0});
		rd(SSIL_ADDR_STAT, 8'h78, 8'h08);
		wr(SSIL_ADDR_CTRL, 8'h10);
		chk(irqs, 8'h00);
		rd(SSIL_ADDR_RXD, 8'hff, 8'h01);
		wr(SSIL_ADDR_MODE, 8'h80);
		wr(SSIL_ADDR_CTRL, 8'h20);
		rd(SSIL_ADDR_STAT, 8'h80, 8'h80);
		wr(SSIL_ADDR_TXD, 8'ha5);
		repeat (40) @(posedge core_clk);
		rd(SSIL_ADDR_STAT, 8'h88, 8'h08);
		wr(SSIL_ADDR_CTRL, 8'h00);
		wr(SSIL_ADDR_STAT, 8'h00);
		wr(SSIL_ADDR_MODE, 8'h00);
		wr(SSIL_ADDR_PORT, 8'h02);
		wr(SSIL_ADDR_CTRL, 8'h20);
		wr(SSIL_ADDR_CTRL, 8'h00);
		chk({6'h0, tx_data_pin_oe, tx_data_pin_out}, 8'h02);
		wr(SSIL_ADDR_MODE, 8'h80);
		wr(SSIL_ADDR_CTRL, 8'h20);
		wr(SSIL_ADDR_CTRL, 8'h00);
		chk({6'h0, tx_data_pin_oe, tx_data_pin_out}, 8'h03);
		@(posedge core_clk);
		#1;
		chk({6'h0, tx_data_pin_oe, tx_data_pin_out}, 8'h02);
		wr(SSIL_ADDR_CTRL, 8'h02);
		chk({6'h0, sck_oe, sck_o}, 8'h01);
		wr(SSIL_ADDR_CTRL, 8'h00);
		wr(SSIL_ADDR_MODE, 8'h00);
		chk({6'h0, sck_oe, sck_o}, 8'h02);
		@(posedge core_clk);
		#1;
		chk({6'h0, sck_oe, sck_o}, 8'h00);
		complete_run();
	end
endmodule // test_serial_status_interrupt_logic
`default_nettype wire
